// ===== logic/fcg_pkg.sv
// Package: addresses, reset values and decode targets for the flash register gate
package fcg_pkg;
  localparam logic [16:0] ADDR_FLASH_CONTROL = 17'h0_FF80;
  localparam logic [16:0] ADDR_ERASE_SEL_1   = 17'h0_FF82;
  localparam logic [16:0] ADDR_ERASE_SEL_2   = 17'h0_FF83;
  localparam logic [16:0] PROG_BEYOND_LO     = 17'h0_8000;
  localparam logic [16:0] PROG_BEYOND_HI     = 17'h1_FFFF;
  localparam logic [7:0]  FLASH_CONTROL_RST  = 8'h80;
  localparam logic [7:0]  ERASE_SEL_RST      = 8'h00;
  localparam logic [7:0]  RESERVED_READ      = 8'hFF;
  localparam int          VOLT_FLAG_BIT      = 7;
  localparam logic [1:0]  MODE_ONE           = 2'h1;
  localparam logic [1:0]  MODE_TWO           = 2'h2;
  localparam logic [1:0]  MODE_THREE         = 2'h3;
  // Access targets, one-hot
  typedef enum logic [2:0] {
    TGT_REG  = 3'b001,
    TGT_RSVD = 3'b010,
    TGT_EXT  = 3'b100
  } fcg_target_type;
endpackage

// ===== logic/fcg_regs.sv
// Register bank for the three flash control registers
`timescale 1ns/1ps
`default_nettype none
module fcg_regs (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       wr_en,
  input  wire logic [1:0] wr_sel,
  input  wire logic [7:0] wr_data,
  input  wire logic       vpp_flag,
  input  wire logic [1:0] rd_sel,
  output logic      [7:0] rd_data
);
  logic [7:0] ctl_r, ctl_nxt;
  logic [7:0] eb1_r, eb1_nxt;
  logic [7:0] eb2_r, eb2_nxt;
  logic [7:0] rd_nxt;

  // Next values; the top control bit mirrors the voltage flag, not software
  always_comb begin
    ctl_nxt = ctl_r;
    eb1_nxt = eb1_r;
    eb2_nxt = eb2_r;
    if (wr_en) begin
      unique case (wr_sel)
        2'd0:    ctl_nxt = wr_data;
        2'd1:    eb1_nxt = wr_data;
        2'd2:    eb2_nxt = wr_data;
        default: ctl_nxt = ctl_r;
      endcase
    end
    ctl_nxt[fcg_pkg::VOLT_FLAG_BIT] = vpp_flag;
    unique case (rd_sel)
      2'd0:    rd_nxt = ctl_r;
      2'd1:    rd_nxt = eb1_r;
      2'd2:    rd_nxt = eb2_r;
      default: rd_nxt = fcg_pkg::RESERVED_READ;
    endcase
  end

  // Registered state and read data
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_r   <= fcg_pkg::FLASH_CONTROL_RST;
      eb1_r   <= fcg_pkg::ERASE_SEL_RST;
      eb2_r   <= fcg_pkg::ERASE_SEL_RST;
      rd_data <= fcg_pkg::RESERVED_READ;
    end else begin
      ctl_r   <= ctl_nxt;
      eb1_r   <= eb1_nxt;
      eb2_r   <= eb2_nxt;
      rd_data <= rd_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== logic/fcg_gate.sv
// Top: access gate and decode for the flash control registers
// How it works
// RULE_01: Control registers sit at FF80, FF82, FF83 and only with high voltage.
// RULE_02: With high voltage, modes 2 and 3 reach registers (control resets 80), mode 1 reads FF.
// RULE_03: Mode 2 without high voltage sends these accesses to external space.
// RULE_04: Mode 3 without high voltage is a reserved area that reads FF and ignores writes.
// RULE_05: The voltage-present flag follows the pin's threshold comparator.
// RULE_06: While the flag is set, writes to all three registers are accepted in every mode except mode 1; code drops them in programmer mode and standby.
// RULE_07: A low standby level on the shared pin forces hardware standby in every mode.
// RULE_08: In programmer mode reads from 8000 to 1FFFF return FF.
// RULE_09: The host holds reset low ten clocks before changing the voltage.
// RULE_10: At power-up the host holds reset through oscillator settling first.
// RULE_11: The host changes the voltage only in reset or when not fetching flash.
// RULE_12: The host does not read flash during a voltage transition.
// RULE_13: The host keeps program and erase bits clear across voltage changes.
// RULE_14: The host starts the watchdog before setting program or erase.
// RULE_15: In mode 2 the host confirms high voltage before accessing the registers.
// RULE_16: Mode and flag are decoded combinationally on each access cycle.
`timescale 1ns/1ps
`default_nettype none
module fcg_gate (
  input  wire logic        CORE_CLK,
  input  wire logic        ARST_N,
  input  wire logic        VPP_HIGH,
  input  wire logic        HALT_PIN_N,
  input  wire logic [1:0]  MODE_PINS,
  input  wire logic        PROG_MODE,
  input  wire logic        ACC_VALID,
  input  wire logic        ACC_WRITE,
  input  wire logic [16:0] ACC_ADDR,
  input  wire logic [7:0]  ACC_WDATA,
  output logic      [7:0]  ACC_RDATA,
  output logic             ACC_EXT,
  output logic             RD_VALID,
  output logic             VPP_FLAG,
  output logic             STANDBY
);
  fcg_pkg::fcg_target_type tgt;
  logic       hit;
  logic       beyond;
  logic [1:0] sel;
  logic       reg_wr;
  logic [1:0] rd_pick;
  logic       ext_nxt, rv_nxt, rsvd_nxt;
  logic       flag_nxt, hardware_halt_pin_nxt;

  // Design notes for whoever picks this up next:
  // - Decode looks at the registered flag, so a pin change is seen one
  //   cycle late; that costs nothing because the host may only move the
  //   voltage in reset or while the core is not fetching flash.
  // - Control bit 7 is not software state: it shows the flag so that
  //   firmware in modes 2 and 3 can see the voltage directly.
  // - Mode 3 without voltage reads all ones on every bit, so software
  //   must compare the whole byte, not bit 7, to detect the voltage.
  // - Addresses next to the window, such as the hole at FF81, read all
  //   ones rather than floating data.
  // - Read data leave the bank's own flop, so the pin stays glitch free
  //   even while the decode inputs are still settling.

  // Address decode of the register window
  function automatic logic [1:0] reg_index(input logic [16:0] a);
    if (a == fcg_pkg::ADDR_FLASH_CONTROL) reg_index = 2'd0;
    else if (a == fcg_pkg::ADDR_ERASE_SEL_1) reg_index = 2'd1;
    else if (a == fcg_pkg::ADDR_ERASE_SEL_2) reg_index = 2'd2;
    else reg_index = 2'd3;
  endfunction

  // ==========================================================
  // Target decode, combinational per access
  always_comb begin
    sel    = reg_index(ACC_ADDR);                  // see RULE_01
    hit    = (sel != 2'd3);
    beyond = (ACC_ADDR >= fcg_pkg::PROG_BEYOND_LO) &&
             (ACC_ADDR <= fcg_pkg::PROG_BEYOND_HI);
    tgt    = fcg_pkg::TGT_EXT;
    if (VPP_FLAG) begin
      if (MODE_PINS == fcg_pkg::MODE_ONE)
        tgt = fcg_pkg::TGT_RSVD;                   // see RULE_02
      else
        tgt = fcg_pkg::TGT_REG;                    // see RULE_16
    end else if (MODE_PINS == fcg_pkg::MODE_THREE) begin
      tgt = fcg_pkg::TGT_RSVD;                     // see RULE_04
    end else begin
      tgt = fcg_pkg::TGT_EXT;                      // see RULE_03
    end
    // Writes land only with the flag set and not in standby
    reg_wr = ACC_VALID && ACC_WRITE && hit && !PROG_MODE && STANDBY == 1'b0
             && tgt == fcg_pkg::TGT_REG;           // see RULE_06
    ext_nxt  = ACC_VALID && hit && !PROG_MODE && !STANDBY
               && tgt == fcg_pkg::TGT_EXT;
    rv_nxt   = ACC_VALID && !ACC_WRITE && !STANDBY;
    rsvd_nxt = PROG_MODE ? beyond                  // see RULE_08
             : !(hit && tgt == fcg_pkg::TGT_REG);
    // Reserved or idle cycles pick the all-ones read path of the bank
    rd_pick  = (rv_nxt && !rsvd_nxt) ? sel : 2'd3;
    flag_nxt = VPP_HIGH;                           // see RULE_05
    hardware_halt_pin_nxt = !HALT_PIN_N;                        // see RULE_07
  end

  fcg_regs u_regs (
    .clk      (CORE_CLK),
    .arst_n   (ARST_N),
    .wr_en    (reg_wr),
    .wr_sel   (sel),
    .wr_data  (ACC_WDATA),
    .vpp_flag (VPP_FLAG),
    .rd_sel   (rd_pick),
    .rd_data  (ACC_RDATA)
  );

  // ==========================================================
  // Status and handshake flops
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      VPP_FLAG <= 1'b0;
      STANDBY  <= 1'b0;
      ACC_EXT  <= 1'b0;
      RD_VALID <= 1'b0;
    end else begin
      VPP_FLAG <= flag_nxt;
      STANDBY  <= hardware_halt_pin_nxt;
      ACC_EXT  <= ext_nxt;
      RD_VALID <= rv_nxt;
    end
  end

  // ==========================================================
  // Checks
  a_mode1_rsvd_read: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    ACC_VALID && !ACC_WRITE && !PROG_MODE && !STANDBY && VPP_FLAG
    && MODE_PINS == fcg_pkg::MODE_ONE && ACC_ADDR == fcg_pkg::ADDR_ERASE_SEL_1
    |=> RD_VALID && ACC_RDATA == fcg_pkg::RESERVED_READ)
    else $error("mode one register read not all ones"); // see RULE_02
  a_mode2_ext_route: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    ACC_VALID && !PROG_MODE && !STANDBY && !VPP_FLAG
    && MODE_PINS == fcg_pkg::MODE_TWO
    && ACC_ADDR == fcg_pkg::ADDR_FLASH_CONTROL |=> ACC_EXT)
    else $error("mode two access not external"); // see RULE_03
  a_mode3_rsvd_read: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    ACC_VALID && !ACC_WRITE && !PROG_MODE && !STANDBY && !VPP_FLAG
    && MODE_PINS == fcg_pkg::MODE_THREE
    |=> ACC_RDATA == fcg_pkg::RESERVED_READ && !ACC_EXT)
    else $error("mode three reserved read wrong"); // see RULE_04
  a_flag_follows: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    VPP_HIGH != $past(VPP_HIGH) |=> VPP_FLAG == $past(VPP_HIGH))
    else $error("voltage flag lags pin"); // see RULE_05
  a_write_readback: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    ACC_VALID && ACC_WRITE && !PROG_MODE && !STANDBY && VPP_FLAG
    && MODE_PINS == fcg_pkg::MODE_THREE && ACC_ADDR == fcg_pkg::ADDR_ERASE_SEL_2
    ##1 ACC_VALID && !ACC_WRITE && !STANDBY && VPP_FLAG && !PROG_MODE
    && MODE_PINS == fcg_pkg::MODE_THREE && ACC_ADDR == fcg_pkg::ADDR_ERASE_SEL_2
    |=> ACC_RDATA == $past(ACC_WDATA, 2))
    else $error("erase select write lost"); // see RULE_06
  a_standby_pin: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    !HALT_PIN_N |=> STANDBY)
    else $error("standby not entered"); // see RULE_07
  a_prog_beyond: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    ACC_VALID && !ACC_WRITE && PROG_MODE && !STANDBY
    && ACC_ADDR >= fcg_pkg::PROG_BEYOND_LO
    |=> RD_VALID && ACC_RDATA == fcg_pkg::RESERVED_READ)
    else $error("programmer read beyond array not FF"); // see RULE_08
  a_no_flag_no_reg: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    !VPP_FLAG |-> !reg_wr)
    else $error("register write without voltage"); // see RULE_01

  // ==========================================================
  // Further checks on blocking, routing and answer shape
  // Standby swallows every access, so no answer may follow it
  a_standby_quiet: assert property ( // see RULE_07
    @(posedge CORE_CLK) disable iff (!ARST_N)
    STANDBY |=> !RD_VALID && !ACC_EXT)
    else $error("answer given in standby");
  // Standby ends one cycle after the pin returns high
  a_standby_leave: assert property ( // see RULE_07
    @(posedge CORE_CLK) disable iff (!ARST_N)
    HALT_PIN_N |=> !STANDBY)
    else $error("standby not left");
  // The flag must drop with the comparator, or writes stay open
  a_flag_clear: assert property ( // see RULE_05
    @(posedge CORE_CLK) disable iff (!ARST_N)
    !VPP_HIGH |=> !VPP_FLAG)
    else $error("voltage flag stuck high");
  // Every read outside standby is answered exactly one cycle later
  a_read_answer: assert property ( // see RULE_16
    @(posedge CORE_CLK) disable iff (!ARST_N)
    ACC_VALID && !ACC_WRITE && !STANDBY |=> RD_VALID)
    else $error("read not answered");
  // Writes give no read answer
  a_write_silent: assert property ( // see RULE_16
    @(posedge CORE_CLK) disable iff (!ARST_N)
    ACC_VALID && ACC_WRITE |=> !RD_VALID)
    else $error("write answered as read");
  // With voltage in mode 2 the window stays internal
  a_mode2_reg_read: assert property ( // see RULE_02
    @(posedge CORE_CLK) disable iff (!ARST_N)
    ACC_VALID && !PROG_MODE && !STANDBY && VPP_FLAG
    && MODE_PINS == fcg_pkg::MODE_TWO && ACC_ADDR == fcg_pkg::ADDR_ERASE_SEL_2
    |=> !ACC_EXT)
    else $error("mode two register access went external");
  // Mode 1 with voltage is reserved, so nothing may be written
  a_mode1_no_write: assert property ( // see RULE_02
    @(posedge CORE_CLK) disable iff (!ARST_N)
    VPP_FLAG && MODE_PINS == fcg_pkg::MODE_ONE |-> !reg_wr)
    else $error("mode one register written");
  // Only the three register addresses are ever rerouted
  a_ext_only_window: assert property ( // see RULE_03
    @(posedge CORE_CLK) disable iff (!ARST_N)
    ACC_VALID && !hit |=> !ACC_EXT)
    else $error("external route outside window");
  // Programmer mode never writes the bank
  a_prog_no_write: assert property ( // see RULE_08
    @(posedge CORE_CLK) disable iff (!ARST_N)
    PROG_MODE |-> !reg_wr)
    else $error("register written in programmer mode");
  // Programmer mode never routes to external space
  a_prog_no_ext: assert property ( // see RULE_08
    @(posedge CORE_CLK) disable iff (!ARST_N)
    ACC_VALID && PROG_MODE |=> !ACC_EXT)
    else $error("programmer access went external");
endmodule
`default_nettype wire

// ===== dv/fcg_vpp_model.sv
// Model of the external programming-voltage controller
`timescale 1ns/1ps
`default_nettype none
module fcg_vpp_model (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic want_high,
  output logic      vpp_high
);
  logic [3:0] held_r = 4'h0;
  initial vpp_high = 1'b0;
  // Voltage moves only after reset has been low ten clocks, so the
  // device never sees a change while it may be fetching from flash
  always @(posedge clk) begin
    if (arst_n) begin
      held_r <= 4'h0;
    end else if (held_r != 4'hA) begin
      held_r <= held_r + 4'h1;
    end else begin
      vpp_high <= want_high;
    end
  end
endmodule
`default_nettype wire

// ===== dv/fcg_gate_test.sv
// Self-checking bench for the flash register gate
`timescale 1ns/1ps
`default_nettype none
module fcg_gate_test;
  logic        clk, rst_n, want, halt_n, prog, valid, wr;
  logic [1:0]  mode;
  logic [16:0] addr;
  logic [7:0]  wdata, rdata, rd;
  logic        ext, rd_valid, flag, hardware_halt_pin, vpp;
  int          bad_count, comparisons;

  fcg_gate fcg_gate_i (.CORE_CLK(clk), .ARST_N(rst_n), .VPP_HIGH(vpp),
    .HALT_PIN_N(halt_n), .MODE_PINS(mode), .PROG_MODE(prog),
    .ACC_VALID(valid), .ACC_WRITE(wr), .ACC_ADDR(addr), .ACC_WDATA(wdata),
    .ACC_RDATA(rdata), .ACC_EXT(ext), .RD_VALID(rd_valid),
    .VPP_FLAG(flag), .STANDBY(hardware_halt_pin));
  fcg_vpp_model fcg_vpp_model_i (.clk(clk), .arst_n(rst_n),
    .want_high(want), .vpp_high(vpp));

  // ==========================================================
  // Access tasks
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // One byte access; the answer is sampled just after the next edge
  task automatic acc(logic w, logic [16:0] a, logic [7:0] d);
    @(posedge clk);
    valid <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    valid <= 1'b0;
    #1;
    rd = rdata;
  endtask
  task automatic rdchk(logic [16:0] a, logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    chk({6'h00, rd_valid, ext}, 8'h02);
    chk(rd, exp);
  endtask
  // Voltage only changes inside a long reset, which also clears registers
  task automatic set_vpp(logic v);
    @(posedge clk);
    rst_n <= 1'b0;
    want <= v;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================================
  // Clock, watchdog and test sequence
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #20us;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    {rst_n, want, valid, wr, prog} = 5'h00;
    halt_n = 1'b1;
    mode = fcg_pkg::MODE_THREE;
    addr = 17'h0_0000;
    wdata = 8'h00;
    bad_count = 0;
    comparisons = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // Mode 3 without voltage: reserved, write dropped
    acc(1'b1, fcg_pkg::ADDR_FLASH_CONTROL, 8'h05);
    rdchk(fcg_pkg::ADDR_FLASH_CONTROL, 8'hFF);
    chk({7'h00, flag}, 8'h00);
    set_vpp(1'b1);
    chk({7'h00, flag}, 8'h01);
    rdchk(fcg_pkg::ADDR_FLASH_CONTROL, 8'h80);
    rdchk(fcg_pkg::ADDR_ERASE_SEL_2, fcg_pkg::ERASE_SEL_RST);
    acc(1'b1, fcg_pkg::ADDR_FLASH_CONTROL, 8'h05);
    acc(1'b1, fcg_pkg::ADDR_ERASE_SEL_1, 8'hA5);
    acc(1'b1, fcg_pkg::ADDR_ERASE_SEL_2, 8'h3C);
    rdchk(fcg_pkg::ADDR_FLASH_CONTROL, 8'h85);
    rdchk(fcg_pkg::ADDR_ERASE_SEL_1, 8'hA5);
    rdchk(fcg_pkg::ADDR_ERASE_SEL_2, 8'h3C);
    // Write then read in back-to-back cycles
    @(posedge clk) begin
      valid <= 1'b1;
      wr <= 1'b1;
      addr <= fcg_pkg::ADDR_ERASE_SEL_2;
      wdata <= 8'h5A;
    end
    @(posedge clk) wr <= 1'b0;
    @(posedge clk) valid <= 1'b0;
    #1 chk(rdata, 8'h5A);
    @(posedge clk) mode <= fcg_pkg::MODE_TWO;
    chk({7'h00, flag}, 8'h01);
    rdchk(fcg_pkg::ADDR_ERASE_SEL_2, 8'h5A);
    // Mode 1 with voltage: reserved area, writes ignored
    @(posedge clk) mode <= fcg_pkg::MODE_ONE;
    acc(1'b1, fcg_pkg::ADDR_ERASE_SEL_1, 8'h11);
    rdchk(fcg_pkg::ADDR_ERASE_SEL_1, 8'hFF);
    @(posedge clk) mode <= fcg_pkg::MODE_THREE;
    rdchk(fcg_pkg::ADDR_ERASE_SEL_1, 8'hA5);
    acc(1'b1, fcg_pkg::ADDR_FLASH_CONTROL, 8'h00);
    set_vpp(1'b0);
    @(posedge clk) mode <= fcg_pkg::MODE_TWO;
    acc(1'b0, fcg_pkg::ADDR_FLASH_CONTROL, 8'h00);
    chk({7'h00, ext}, 8'h01);
    // Programmer mode reads above the array
    @(posedge clk) mode <= fcg_pkg::MODE_THREE;
    prog <= 1'b1;
    rdchk(fcg_pkg::PROG_BEYOND_LO, 8'hFF);
    rdchk(fcg_pkg::PROG_BEYOND_HI, 8'hFF);
    // Shared pin low enters standby even in programmer mode
    @(posedge clk) halt_n <= 1'b0;
    @(posedge clk);
    #1 chk({7'h00, hardware_halt_pin}, 8'h01);
    acc(1'b0, fcg_pkg::PROG_BEYOND_LO, 8'h00);
    chk({7'h00, rd_valid}, 8'h00);
    @(posedge clk) halt_n <= 1'b1;
    @(posedge clk);
    #1 chk({7'h00, hardware_halt_pin}, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
